/* File: test/drive_engine_model.sv */
// Behavioural drive engine that answers launch and initialize pulses
module drive_engine_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Launch side
  input wire logic eng_start,
  input wire logic eng_init,
  // Scenario controls
  input wire logic [3:0] lat,
  input wire logic crc_bad,
  input wire logic disk_den,
  input wire logic dual,
  // Result side
  output logic eng_done,
  output logic eng_crc_err,
  output logic eng_nxm,
  output logic eng_deleted,
  output logic eng_drive_ready,
  output logic eng_disk_density,
  output logic eng_dual_sided
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt_r;
  logic junk_r;
  // Results other than eng_dual_sided mean something only with eng_done, so they toggle in between
  assign eng_crc_err = eng_done ? crc_bad : junk_r;
  assign eng_nxm = eng_done ? 1'b0 : junk_r;
  assign eng_deleted = eng_done ? 1'b0 : junk_r;
  assign eng_drive_ready = eng_done ? 1'b1 : junk_r;
  assign eng_disk_density = eng_done ? disk_den : junk_r;
  assign eng_dual_sided = dual;
  always_ff @(posedge aclk) begin
    eng_done <= 1'b0;
    junk_r <= aresetn ? ~junk_r : 1'b0;
    if (!aresetn) begin
      cnt_r <= 5'h00;
    end else if (eng_start || eng_init) begin
      cnt_r <= {1'b0, lat} + 5'h01;
    end else if (cnt_r != 5'h00) begin
      cnt_r <= cnt_r - 5'h01;
      eng_done <= (cnt_r == 5'h01);
    end
  end
endmodule // drive_engine_model

/* File: test/floppy_host_regs_test.sv */
// Self-checking bench for the floppy host register bank
module floppy_host_regs_test
  import floppy_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  //////////////////////////////////////////////////////////////////////////
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1;
  logic s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic selftest_sw = 1'b1;
  logic eng_start, eng_density, eng_unit, eng_side, eng_init, eng_selftest, irq;
  logic [2:0] eng_func;
  logic [6:0] eng_track;
  logic [7:0] eng_sector, eng_wcount;
  logic [17:0] eng_bus_addr;
  logic eng_done, eng_crc_err, eng_nxm, eng_deleted, eng_drive_ready;
  logic eng_disk_density, eng_dual_sided;
  logic [3:0] lat = 4'h3;
  logic crc_bad = 1'b0;
  logic disk_den = 1'b0;
  logic dual = 1'b1;
  int num_errors = 0;
  int compares = 0;
  int starts = 0;
  int irqs = 0;
  int inits = 0;

  always #5 aclk = ~aclk;

  floppy_host_regs i_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .selftest_sw, .eng_start, .eng_func,
    .eng_density, .eng_unit, .eng_side, .eng_track, .eng_sector, .eng_wcount,
    .eng_bus_addr, .eng_init, .eng_selftest, .eng_done, .eng_crc_err, .eng_nxm,
    .eng_deleted, .eng_drive_ready, .eng_disk_density, .eng_dual_sided, .irq
  );

  drive_engine_model i_engine (
    .aclk, .aresetn, .eng_start, .eng_init, .lat, .crc_bad, .disk_den, .dual,
    .eng_done, .eng_crc_err, .eng_nxm, .eng_deleted, .eng_drive_ready,
    .eng_disk_density, .eng_dual_sided
  );

  // Pulse counters update late in the step so the tests read settled counts
  always @(posedge aclk) begin
    if (eng_start === 1'b1) starts <= starts + 1;
    if (irq === 1'b1) irqs <= irqs + 1;
    if (eng_init === 1'b1) inits <= inits + 1;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", w, e, g);
    end
  endtask

  task automatic axw(input logic [3:0] a, input logic [15:0] d, output logic [1:0] r);
    logic ad, wd;
    int n;
    ad = 1'b0;
    wd = 1'b0;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        ad = 1'b1;
      end
      if (s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        wd = 1'b1;
      end
      n++;
    end while (!(ad && wd && s_axi_bvalid) && n < 50);
    if (n >= 50) num_errors++;
    r = s_axi_bresp;
  endtask

  task automatic axr(input logic [3:0] a, output logic [15:0] d, output logic [1:0] r);
    logic ad;
    int n;
    ad = 1'b0;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        ad = 1'b1;
      end
      n++;
    end while (!(ad && s_axi_rvalid) && n < 50);
    if (n >= 50) num_errors++;
    d = s_axi_rdata[15:0];
    r = s_axi_rresp;
  endtask

  task automatic poll(input int b, output logic [15:0] v);
    logic [1:0] r;
    int n;
    n = 0;
    do begin
      axr(CSR_OFF, v, r);
      n++;
    end while (v[b] !== 1'b1 && n < 40);
    if (n >= 40) num_errors++;
  endtask

  task automatic cmd(input logic [15:0] c, input int np, input logic [15:0] p0, p1,
                     output logic [15:0] cs, st);
    logic [15:0] v;
    logic [1:0] r;
    axw(CSR_OFF, c, r);
    if (np > 0) begin
      poll(TR_BIT, v);
      chk("param request", 1, v[TR_BIT]);
      axw(DBR_OFF, p0, r);
    end
    if (np > 1) begin
      poll(TR_BIT, v);
      axw(DBR_OFF, p1, r);
    end
    poll(DONE_BIT, cs);
    axr(DBR_OFF, st, r);
    repeat (2) @(posedge aclk);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    report_and_stop;
  end

  initial begin
    logic [15:0] cs, st, v;
    logic [1:0] r;
    logic [15:0] wc_t [4] = '{16'h0041, 16'h0081, 16'h0000, 16'h0080};
    logic [15:0] sec_t [4] = '{16'h0001, 16'h0001, 16'h0001, 16'hab1a};
    logic [15:0] trk_t [4] = '{16'h004d, 16'h0001, 16'h0001, 16'hff4c};
    int n0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    poll(DONE_BIT, cs);
    axr(DBR_OFF, st, r);
    chk("csr after init", 32'h0820, cs);
    chk("init done", 32'h4, st & 16'h0004);
    chk("init target", {3'h3, 7'h01, 8'h01}, {eng_func, eng_track, eng_sector});
    chk("init unit", 0, eng_unit);
    chk("power-on self test", 1, eng_selftest);
    $display("test power-on finished");
    // Word count limits; ext bits 13:12 = 10
    for (int i = 0; i < 4; i++) begin
      n0 = starts;
      cmd(16'h2001 | (i[0] << 8), 2, wc_t[i], 16'h1234, cs, st);
      chk("wc err", i < 2, cs[ERR_BIT]);
      chk("wc overflow", i < 2, st[SW_WCO]);
      chk("wc started", n0 + (i == 3), starts);
    end
    chk("wc and address", {8'h80, 18'h21234}, {eng_wcount, eng_bus_addr});
    chk("csr density", 32'h0920, cs);
    $display("test word count finished");
    // Track limit, density mismatch, crc, then a clean read with junk high bytes
    for (int i = 0; i < 4; i++) begin
      disk_den <= (i != 1);
      crc_bad <= (i == 2);
      cmd(16'h0307, 2, sec_t[i], trk_t[i], cs, st);
      chk("read err", i < 3, cs[ERR_BIT]);
      chk("read status", (i == 1) ? 32'h10 : (i == 2) ? 32'h1 : 32'h0, st & 16'h0011);
    end
    chk("track sector side", {7'h4c, 8'h1a, 1'b1}, {eng_track, eng_sector, eng_side});
    $display("test read checks finished");
    // Every function code, side bit dropped on single-sided drive
    dual <= 1'b0;
    for (int f = 0; f < 8; f++) begin
      n0 = starts;
      cmd(16'h0301 | (f << 1), (f == 5) ? 0 : (f == 4 || f == 7) ? 1 : 2,
          (f == 4) ? MODE_DENSITY : 16'h0001, 16'h0001, cs, st);
      chk("func and side", f, {eng_side, eng_func});
      chk("func started", n0 + 1, starts);
      chk("func err", 0, cs[ERR_BIT]);
    end
    $display("test functions finished");
    disk_den <= 1'b0;
    n0 = irqs;
    axw(CSR_OFF, 16'h0040, r);
    repeat (2) @(posedge aclk);
    chk("irq on enable", n0 + 1, irqs);
    axr(CSR_OFF, cs, r);
    chk("enable readback", 32'h40, cs & 16'h0040);
    axw(CSR_OFF, 16'h0000, r);
    axw(CSR_OFF, 16'h004b, r);
    repeat (2) @(posedge aclk);
    chk("irq with start", n0 + 1, irqs);
    poll(DONE_BIT, cs);
    repeat (2) @(posedge aclk);
    chk("irq at finish", n0 + 2, irqs);
    $display("test interrupts finished");
    lat <= 4'hf;
    axw(CSR_OFF, 16'h000b, r);
    axw(CSR_OFF, 16'h0050, r);
    poll(DONE_BIT, cs);
    chk("busy write ignored", 0, cs & 16'h0050);
    axw(CSR_OFF, 16'h0010, r);
    axr(CSR_OFF, cs, r);
    chk("unit when done", 32'h10, cs & 16'h0010);
    axw(CSR_OFF, 16'h011b, r);
    axr(CSR_OFF, cs, r);
    chk("unit hidden busy", 0, cs & 16'h0130);
    poll(DONE_BIT, cs);
    chk("busy err", 1, cs[ERR_BIT]);
    axw(CSR_OFF, 16'h0040, r);
    axw(CSR_OFF, 16'h4000, r);
    axr(CSR_OFF, cs, r);
    chk("done cleared", 0, cs & 16'h0020);
    poll(DONE_BIT, cs);
    chk("csr after reinit", 32'h0820, cs);
    chk("init pulses", 2, inits);
    chk("self test", 1, eng_selftest);
    lat <= 4'h3;
    $display("test busy and initialize finished");
    for (int i = 0; i < 2; i++) begin
      cmd(16'h0009, 1, i ? MODE_EXTENDED : 16'h1234, 16'h0000, cs, st);
      chk("mode check", i == 0, cs[ERR_BIT]);
    end
    axw(4'h8, 16'h0001, r);
    chk("unmapped write", RESP_SLVERR, r);
    axr(4'hc, v, r);
    chk("unmapped read", {RESP_SLVERR, 16'h0}, {r, v});
    $display("test mode and unmapped finished");
    report_and_stop;
  end
endmodule // floppy_host_regs_test

/* File: verilog/floppy_host_regs.sv */
// Host register bank of the floppy controller on an AXI4-Lite slave
//
// Our own choices: the placing of the registers and the AXI4-Lite register port.
module floppy_host_regs
  import floppy_regs_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Self-test switch pin
  input wire logic selftest_sw,
  // Drive engine command side
  output logic eng_start,
  output logic [2:0] eng_func,
  output logic eng_density,
  output logic eng_unit,
  output logic eng_side,
  output logic [6:0] eng_track,
  output logic [7:0] eng_sector,
  output logic [7:0] eng_wcount,
  output logic [17:0] eng_bus_addr,
  output logic eng_init,
  output logic eng_selftest,
  // Drive engine result side
  input wire logic eng_done,
  input wire logic eng_crc_err,
  input wire logic eng_nxm,
  input wire logic eng_deleted,
  input wire logic eng_drive_ready,
  input wire logic eng_disk_density,
  input wire logic eng_dual_sided,
  // Host interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [1:0] param_count(input logic [2:0] f);
    unique case (f)
      FN_DENSITY, FN_ERRCODE: param_count = 2'h1;
      FN_STATUS: param_count = 2'h0;
      default: param_count = 2'h2;
    endcase
  endfunction

  function automatic logic density_checked(input logic [2:0] f);
    density_checked = (f == FN_READ) || (f == FN_WRITE) || (f == FN_WDEL)
                      || (f == FN_STATUS);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave state
  logic aw_full_r, w_full_r, awready_r, wready_r, bvalid_r;
  logic [1:0] bresp_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic arready_r, rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;

  // Block state
  state_e st_r, st_nxt;
  logic done_r, err_r, ie_r, tr_r, den_r, unit_r, side_r;
  logic [1:0] ea_r;
  logic [2:0] fn_r;
  logic [15:0] p0_r, p1_r, sw_r;
  logic [1:0] pidx_r;
  logic init_pend_r;
  logic sw_meta_r, sw_sync_r;
  logic start_r, init_r, selftest_r, irq_r, side_out_r, den_out_r, unit_out_r;
  logic [2:0] func_out_r;
  logic [6:0] track_r;
  logic [7:0] sector_r, wcount_r;
  logic [17:0] baddr_r;

  ////////////////////////////////////////////////////////////////////////////
  // Write address and data may arrive in either order; one write at a time
  wire aw_hs = s_axi_awvalid & awready_r;
  wire w_hs = s_axi_wvalid & wready_r;
  wire do_write = aw_full_r & w_full_r & ~bvalid_r;
  wire aw_full_nxt = aw_full_r ? ~do_write : aw_hs;
  wire w_full_nxt = w_full_r ? ~do_write : w_hs;
  wire wa_csr = aw_addr_r == CSR_OFF;
  wire wa_dbr = aw_addr_r == DBR_OFF;
  wire [15:0] lane_mask = {{8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  wire [15:0] wd = w_data_r[15:0] & lane_mask;
  wire wr_csr = do_write & wa_csr & (|w_strb_r[1:0]);
  wire wr_dbr = do_write & wa_dbr & (|w_strb_r[1:0]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      awready_r <= ~aw_full_nxt;
      wready_r <= ~w_full_nxt;
      if (do_write) begin
        bvalid_r <= 1'b1;
        bresp_r <= (wa_csr | wa_dbr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (aw_hs) begin
      aw_addr_r <= s_axi_awaddr;
    end
    if (w_hs) begin
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read side: answer the cycle after the address is taken
  wire ar_hs = s_axi_arvalid & arready_r;
  wire rvalid_nxt = ar_hs | (rvalid_r & ~s_axi_rready);
  wire ra_csr = s_axi_araddr == CSR_OFF;
  wire ra_dbr = s_axi_araddr == DBR_OFF;
  // Density and unit only read back once the command has finished
  wire [15:0] csr_rd = {err_r, 1'b0, 2'h0, 1'b1, 1'b0, 1'b0, den_r & done_r,
                        tr_r, ie_r, done_r, unit_r & done_r, 4'h0};
  wire [15:0] rd_mux = ra_csr ? csr_rd : (ra_dbr ? sw_r : 16'h0000);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end else begin
      arready_r <= ~rvalid_nxt;
      rvalid_r <= rvalid_nxt;
      if (ar_hs) begin
        rdata_r <= {16'h0000, rd_mux};
        rresp_r <= (ra_csr | ra_dbr) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode; the whole COMMAND_STATUS_REG write is dropped while busy, only
  // initialize gets through so software can always recover
  wire init_req = wr_csr & wd[INIT_BIT];
  wire cmd_ok = wr_csr & done_r & ~init_req & (st_r == ST_IDLE);
  wire go = cmd_ok & wd[GO_BIT];
  wire [2:0] wfn = wd[FN_LSB +: 3];
  wire [1:0] wcnt = param_count(wfn);
  wire dbr_take = wr_dbr & tr_r;
  wire last_param = dbr_take & ((pidx_r + 2'h1) == param_count(fn_r));

  // Parameter checks, upper bytes ignored except by the mode check
  wire [7:0] wc = p0_r[7:0];
  wire [7:0] wc_lim = den_r ? WC_MAX_DD : WC_MAX_SD;
  wire is_xfer = (fn_r == FN_FILL) | (fn_r == FN_EMPTY);
  wire is_sect = (fn_r == FN_READ) | (fn_r == FN_WRITE) | (fn_r == FN_WDEL);
  wire wc_over = is_xfer & (wc > wc_lim);
  wire wc_zero = is_xfer & (wc == 8'h00);
  wire trk_bad = is_sect & (p1_r[7:0] > TRACK_MAX);
  wire mode_bad = (fn_r == FN_DENSITY) & (p0_r != MODE_DENSITY)
                  & (p0_r != MODE_EXTENDED);
  wire chk_fail = wc_over | trk_bad | mode_bad;
  wire chk_end = (st_r == ST_CHECK) & (chk_fail | wc_zero) & ~init_req;
  wire launch = (st_r == ST_CHECK) & ~chk_fail & ~wc_zero & ~init_req;

  // Completion from the drive engine
  wire den_mis = density_checked(fn_r) & (den_r != eng_disk_density);
  wire exec_end = (st_r == ST_EXEC) & eng_done & ~init_req;
  wire exec_err = eng_crc_err | eng_nxm | den_mis;
  wire init_end = (st_r == ST_INIT) & eng_done & ~init_pend_r & ~init_req;
  wire cmd_end = chk_end | exec_end;
  wire fin = cmd_end | init_end;
  wire fin_err = chk_end ? chk_fail : (exec_end & exec_err);

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_IDLE: begin
        if (go) begin
          st_nxt = (wcnt == 2'h0) ? ST_CHECK : ST_PARAM;
        end
      end
      ST_PARAM: begin
        if (last_param) begin
          st_nxt = ST_CHECK;
        end
      end
      ST_CHECK: st_nxt = launch ? ST_EXEC : ST_IDLE;
      ST_EXEC: begin
        if (eng_done) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_INIT: begin
        if (init_end) begin
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_INIT;
    endcase
    if (init_req) begin
      st_nxt = ST_INIT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags; finishing never meets a start or initialize in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= ST_INIT;
      init_pend_r <= 1'b1;
      done_r <= 1'b0;
      err_r <= 1'b0;
      ie_r <= 1'b0;
      tr_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      init_pend_r <= init_req | (init_pend_r & (st_r != ST_INIT));
      if (init_req | go) begin
        done_r <= 1'b0;
        err_r <= 1'b0;
      end else if (fin) begin
        done_r <= 1'b1;
        err_r <= fin_err;
      end
      if (init_req) begin
        ie_r <= 1'b0;
      end else if (cmd_ok) begin
        ie_r <= wd[IE_BIT];
      end
      tr_r <= (st_nxt == ST_PARAM) & ~dbr_take;
    end
  end

  // Command fields latched only from an accepted write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fn_r <= FN_FILL;
      den_r <= 1'b0;
      unit_r <= 1'b0;
      side_r <= 1'b0;
      ea_r <= 2'h0;
    end else if (cmd_ok) begin
      fn_r <= wfn;
      den_r <= wd[DEN_BIT];
      unit_r <= wd[UNIT_BIT];
      side_r <= wd[SIDE_BIT];
      ea_r <= wd[EA_LSB +: 2];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pidx_r <= 2'h0;
      p0_r <= 16'h0000;
      p1_r <= 16'h0000;
    end else begin
      if (go) begin
        pidx_r <= 2'h0;
      end else if (dbr_take) begin
        pidx_r <= pidx_r + 2'h1;
      end
      if (dbr_take & (pidx_r == 2'h0)) begin
        p0_r <= wd;
      end
      if (dbr_take & (pidx_r == 2'h1)) begin
        p1_r <= wd;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status word rebuilt at every finish; the init-done bit survives only
  // until the next command ends
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_r <= SW_RESET;
    end else if (fin) begin
      sw_r <= 16'h0000;
      sw_r[SW_WCO] <= chk_end & wc_over;
      sw_r[SW_NXM] <= exec_end & eng_nxm;
      sw_r[SW_CRC] <= exec_end & eng_crc_err;
      sw_r[SW_DENERR] <= exec_end & den_mis;
      sw_r[SW_DEL] <= exec_end & eng_deleted;
      sw_r[SW_INITD] <= init_end;
      sw_r[SW_UNIT] <= init_end ? INIT_UNIT : unit_r;
      sw_r[SW_DRDY] <= eng_drive_ready;
      sw_r[SW_DDEN] <= eng_disk_density;
      sw_r[SW_DSIDE] <= eng_dual_sided;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Switch pin synchroniser; left out of reset so the power-on initialize
  // already sees the settled switch level
  always_ff @(posedge aclk) begin
    sw_meta_r <= selftest_sw;
    sw_sync_r <= sw_meta_r;
  end

  // Engine requests; the address comes from the parameter that holds it
  wire [15:0] addr_param = (fn_r == FN_ERRCODE) ? p0_r : p1_r;
  wire init_go = (st_r == ST_INIT) & init_pend_r & ~init_req;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_r <= 1'b0;
      init_r <= 1'b0;
      selftest_r <= 1'b0;
      func_out_r <= FN_FILL;
      den_out_r <= 1'b0;
      unit_out_r <= 1'b0;
      side_out_r <= 1'b0;
      track_r <= 7'h00;
      sector_r <= 8'h00;
      wcount_r <= 8'h00;
      baddr_r <= 18'h00000;
    end else begin
      start_r <= launch;
      init_r <= init_go;
      if (init_go) begin
        selftest_r <= sw_sync_r;
        func_out_r <= FN_READ;
        unit_out_r <= INIT_UNIT;
        side_out_r <= 1'b0;
        track_r <= INIT_TRACK;
        sector_r <= INIT_SECTOR;
      end else if (launch) begin
        func_out_r <= fn_r;
        den_out_r <= den_r;
        unit_out_r <= unit_r;
        side_out_r <= side_r & eng_dual_sided;
        track_r <= p1_r[6:0];
        sector_r <= p0_r[7:0];
        wcount_r <= wc;
        baddr_r <= {ea_r, addr_param};
      end
    end
  end

  // Interrupt pulse on done rising or enable rising over a standing done
  wire ie_rise = cmd_ok & ~ie_r & wd[IE_BIT] & ~wd[GO_BIT];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= (fin & ie_r) | ie_rise;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign eng_start = start_r;
  assign eng_init = init_r;
  assign eng_selftest = selftest_r;
  assign eng_func = func_out_r;
  assign eng_density = den_out_r;
  assign eng_unit = unit_out_r;
  assign eng_side = side_out_r;
  assign eng_track = track_r;
  assign eng_sector = sector_r;
  assign eng_wcount = wcount_r;
  assign eng_bus_addr = baddr_r;
  assign irq = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  id_bit_a: assert property (ar_hs & ra_csr |=> rdata_r[ID_BIT])
    else $error("id bit read as zero");
  go_clears_a: assert property (go |=> !done_r && !err_r)
    else $error("start left done or error set");
  init_done_a: assert property (init_req |=> !done_r ##1 !done_r)
    else $error("initialize did not hold done low");
  init_ie_a: assert property (init_req |=> !ie_r && !err_r)
    else $error("initialize left enable set");
  busy_drop_a: assert property (wr_csr & !done_r & !init_req |=> $stable(ie_r)
    && $stable(fn_r)) else $error("busy write changed state");
  tr_clear_a: assert property (dbr_take |=> !tr_r)
    else $error("parameter write left request set");
  ie_irq_a: assert property (ie_rise |=> irq_r)
    else $error("enable rise gave no interrupt");
  go_ie_a: assert property (go & wd[IE_BIT] |=> !irq_r ##1 !irq_r)
    else $error("interrupt before command end");
  wco_a: assert property ((st_r == ST_CHECK) & wc_over & !init_req
    |=> done_r && err_r && sw_r[SW_WCO]) else $error("overflow not flagged");
  den_rd_a: assert property (ar_hs & ra_csr & !done_r |=> !rdata_r[DEN_BIT])
    else $error("density visible while busy");
  crc_a: assert property (exec_end & eng_crc_err |=> err_r && sw_r[SW_CRC])
    else $error("crc error not reported");

  go_c: cover property (go ##[1:20] exec_end);
  init_c: cover property (init_req ##[1:40] init_end);
  wco_c: cover property (chk_end & wc_over);
  irq_c: cover property (irq_r);

endmodule // floppy_host_regs

/* File: verilog/floppy_regs_pkg.sv */
// Constants, codes and states of the floppy controller host register bank
package floppy_regs_pkg;
  // Register byte offsets
  localparam logic [3:0] CSR_OFF = 4'h0;
  localparam logic [3:0] DBR_OFF = 4'h4;
  // Command and status register fields
  localparam int ERR_BIT = 15;
  localparam int INIT_BIT = 14;
  localparam int EA_LSB = 12;
  localparam int ID_BIT = 11;
  localparam int SIDE_BIT = 9;
  localparam int DEN_BIT = 8;
  localparam int TR_BIT = 7;
  localparam int IE_BIT = 6;
  localparam int DONE_BIT = 5;
  localparam int UNIT_BIT = 4;
  localparam int FN_LSB = 1;
  localparam int GO_BIT = 0;
  // Error and status word fields
  localparam int SW_CRC = 0;
  localparam int SW_DSIDE = 1;
  localparam int SW_INITD = 2;
  localparam int SW_DENERR = 4;
  localparam int SW_DDEN = 5;
  localparam int SW_DEL = 6;
  localparam int SW_DRDY = 7;
  localparam int SW_UNIT = 8;
  localparam int SW_WCO = 10;
  localparam int SW_NXM = 11;
  // Parameter limits and codes
  localparam logic [7:0] WC_MAX_DD = 8'h80;
  localparam logic [7:0] WC_MAX_SD = 8'h40;
  localparam logic [7:0] TRACK_MAX = 8'h4c;
  localparam logic [15:0] MODE_DENSITY = 16'h0049;
  localparam logic [15:0] MODE_EXTENDED = 16'h5345;
  localparam logic [6:0] INIT_TRACK = 7'h01;
  localparam logic [7:0] INIT_SECTOR = 8'h01;
  localparam logic INIT_UNIT = 1'b0;
  // Reset values and bus response codes
  localparam logic [15:0] SW_RESET = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    FN_FILL = 3'h0, FN_EMPTY = 3'h1, FN_WRITE = 3'h2, FN_READ = 3'h3,
    FN_DENSITY = 3'h4, FN_STATUS = 3'h5, FN_WDEL = 3'h6, FN_ERRCODE = 3'h7
  } func_e;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01, ST_PARAM = 5'h02, ST_CHECK = 5'h04,
    ST_EXEC = 5'h08, ST_INIT = 5'h10
  } state_e;
endpackage
